// *** logic/bme_byte_move.sv ***
// Byte transfer and exchange executor with cycle accounting
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bme_byte_move
(
	input wire logic clk,
	input wire logic rst_b,
	input wire bme_pkg::bme_bus_t bus,
	output logic [31:0] rdata,
	output logic busy,
	output logic done,
	output bme_pkg::bme_mem_t mem
);
	import bme_pkg::*;

	bme_state_t state;
	bme_op_t op_q;
	logic [4:0] ea_q;
	logic [2:0] bsel_q;
	bme_size_t sz_q;
	logic [15:0] ext_q;
	logic [15:0] pc_q;
	logic [31:0] cfg_q;
	logic [15:0] acc_low_half;
	logic [15:0] acc_high_half;
	logic [6:0] flags;
	logic [7:0][15:0] word_general_reg;
	logic [7:0][15:0] next_wreg;
	logic [7:0] total_q;
	logic [7:0] cnt_q;
	logic [7:0] run_len;
	logic [3:0] register_access_count;
	logic [3:0] len_q;
	logic err_q;
	bme_ea_t ea;
	bme_loc_t loc;
	bme_fetch_t fetch;
	logic [3:0] waits;
	logic [7:0] mem_byte;
	logic sw_wr;
	logic cmd_wr;
	logic commit;
	logic is_eam;
	logic is_ear;
	logic mem_op;
	logic swap_mem;
	logic nz_op;
	logic [15:0] opnd_addr;
	logic [6:0] cr;
	logic [7:0] mult;
	logic [7:0] next_total;
	logic [3:0] next_rac;
	logic [3:0] next_len;
	logic next_err;
	logic [15:0] next_lo;
	logic [15:0] next_hi;
	logic [7:0] res;
	logic [6:0] flag_val;
	bme_mem_t next_mem;
	logic [31:0] rmux;

	assign loc = bme_loc_t'(cfg_q[CFG_LOC +: 2]);
	assign fetch = bme_fetch_t'(cfg_q[CFG_FETCH +: 2]);
	assign waits = cfg_q[CFG_WAIT +: 4];
	assign mem_byte = cfg_q[CFG_MEM +: 8];
	assign sw_wr = bus.wr && state == ST_IDLE;
	assign cmd_wr = sw_wr && bus.addr == OFS_CMD;
	assign commit = state == ST_RUN && cnt_q == 8'h01;
	assign busy = state != ST_IDLE;

	bme_ea_dec u_ea_dec
	(
		.ea_code(ea_q),
		.size(sz_q),
		.word_general_reg(word_general_reg),
		.ext(ext_q),
		.pc(pc_q),
		.ea(ea)
	);

	// Operand correction: cycles in [6:3], accesses in [2:0]
	function automatic logic [6:0] corr(bme_size_t sz, bme_loc_t lc,
		logic odd);
		logic [6:0] r;
		r = {4'h0, ACC_ONE};
		case (sz)
		SZ_BYTE: r = {(lc == LOC_INT) ? 4'h0 : COR_B_EXT, ACC_ONE};
		SZ_WORD:
			if (lc == LOC_INT)
				r = odd ? {COR_W_ODD_INT, ACC_TWO} : {4'h0, ACC_ONE};
			else if (lc == LOC_EXT16 && !odd)
				r = {COR_E16_EVEN, ACC_ONE};
			else
				r = {COR_W_EXT, ACC_TWO};
		SZ_LONG:
			if (lc == LOC_INT)
				r = odd ? {COR_L_ODD_INT, ACC_FOUR} : {4'h0, ACC_TWO};
			else if (lc == LOC_EXT16 && !odd)
				r = {COR_L_E16_EVEN, ACC_TWO};
			else
				r = {COR_L_EXT, ACC_FOUR};
		default: r = {4'h0, ACC_ONE};
		endcase
		return r;
	endfunction

	function automatic bme_fact_t flag_act(logic nz, int idx);
		bme_fact_t a;
		a = FA_KEEP;
		if (nz && (idx == FLG_N || idx == FLG_Z))
			a = FA_CHG;
		return a;
	endfunction

	always_comb
	begin
		is_eam = op_q == OP_LD_EAM || op_q == OP_LDX_EAM ||
			op_q == OP_SWP_A_EAM || op_q == OP_SWP_R_EAM;
		is_ear = op_q == OP_LD_EAR || op_q == OP_SWP_A_EAR ||
			op_q == OP_SWP_R_EAR;
		mem_op = !is_ear;
		swap_mem = op_q == OP_SWP_A_EAM || op_q == OP_SWP_R_EAM;
		nz_op = op_q <= OP_ST_IND;
		case (op_q)
		OP_LD_ABS, OP_LDX_ABS: opnd_addr = ext_q;
		OP_ST_IND: opnd_addr = acc_low_half;
		OP_ST_IO_IMM: opnd_addr = {8'h00, ext_q[7:0]};
		OP_ST_DIR_IMM: opnd_addr = {cfg_q[CFG_DPR +: 8], ext_q[7:0]};
		default: opnd_addr = ea.addr;
		endcase
	end

	always_comb
	begin
		next_err = (is_eam && ea.is_reg) || (is_ear && !ea.is_reg) ||
			op_q > OP_SWP_R_EAM;
		next_total = 8'h01;
		next_rac = 4'h0;
		next_len = 4'h0;
		cr = corr(sz_q, loc, opnd_addr[0]);
		mult = swap_mem ? 8'h02 : 8'h01;
		if (!next_err)
		begin
			next_total = BASE_CYC[op_q];
			next_rac = BASE_RAC[op_q];
			next_len = BASE_LEN[op_q];
			if (is_eam)
			begin
				next_total = next_total + 8'(ea.a_cyc);
				next_rac = next_rac + 4'(ea.a_rac);
				next_len = next_len + 4'(ea.ext_cnt);
			end
			if (mem_op)
				next_total = next_total + 8'(cr[6:3]) * mult;
			if (mem_op && loc != LOC_INT)
				next_total = next_total +
					8'(waits) * 8'(cr[2:0]) * mult;
			case (fetch)
			FET_INT_WORD: next_total = next_total + FET_INT_CYC;
			FET_E16_WORD, FET_E8_BYTE:
				next_total = next_total + FET_EXT_CYC;
			default: next_total = next_total;
			endcase
			if (cfg_q[CFG_INTM])
				next_total = next_total + 8'(next_rac);
		end
	end

	always_comb
	begin
		next_lo = acc_low_half;
		next_hi = acc_high_half;
		next_wreg = word_general_reg;
		next_mem = '0;
		res = 8'h00;
		case (op_q)
		OP_LD_ABS, OP_LDX_ABS, OP_LD_EAM, OP_LDX_EAM, OP_LD_EAR:
		begin
			res = (op_q == OP_LD_EAR) ?
				word_general_reg[ea.reg_idx][7:0] : mem_byte;
			next_hi = acc_low_half;
			next_lo = {(op_q == OP_LDX_ABS || op_q == OP_LDX_EAM) ?
				{8{res[7]}} : 8'h00, res};
		end
		OP_ST_IND:
		begin
			res = acc_high_half[7:0];
			next_mem = {1'b1, opnd_addr, res};
		end
		OP_ST_IO_IMM, OP_ST_DIR_IMM:
			next_mem = {1'b1, opnd_addr, ext_q[15:8]};
		OP_SWP_A_EAR:
		begin
			next_lo = {8'h00, word_general_reg[ea.reg_idx][7:0]};
			next_wreg[ea.reg_idx][7:0] = acc_low_half[7:0];
		end
		OP_SWP_A_EAM:
		begin
			next_lo = {8'h00, mem_byte};
			next_mem = {1'b1, opnd_addr, acc_low_half[7:0]};
		end
		OP_SWP_R_EAR:
		begin
			next_wreg[bsel_q][7:0] = word_general_reg[ea.reg_idx][7:0];
			next_wreg[ea.reg_idx][7:0] = word_general_reg[bsel_q][7:0];
		end
		OP_SWP_R_EAM:
		begin
			next_wreg[bsel_q][7:0] = mem_byte;
			next_mem = {1'b1, opnd_addr, word_general_reg[bsel_q][7:0]};
		end
		default: next_mem = '0;
		endcase
		if (is_eam && ea.post_inc)
			next_wreg[ea.ptr_idx] = word_general_reg[ea.ptr_idx] +
				((sz_q == SZ_LONG) ? STEP_L :
				(sz_q == SZ_WORD) ? STEP_W : STEP_B);
		flag_val = '0;
		flag_val[FLG_N] = res[7];
		flag_val[FLG_Z] = res == 8'h00;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			state <= ST_IDLE;
		else
			case (state)
			ST_IDLE: if (cmd_wr) state <= ST_DEC;
			ST_DEC: state <= next_err ? ST_IDLE : ST_RUN;
			ST_RUN: if (cnt_q == 8'h01) state <= ST_IDLE;
			default: state <= ST_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			op_q <= OP_LD_ABS;
			ea_q <= 5'h00;
			bsel_q <= 3'h0;
			sz_q <= SZ_BYTE;
		end
		else if (cmd_wr)
		begin
			op_q <= bme_op_t'(bus.wdata[CMD_OP +: 4]);
			ea_q <= bus.wdata[CMD_EA +: 5];
			bsel_q <= bus.wdata[CMD_BSEL +: 3];
			sz_q <= bme_size_t'(bus.wdata[CMD_SZ +: 2]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ext_q <= WORD_RST;
			pc_q <= WORD_RST;
			cfg_q <= CFG_RST;
		end
		else if (sw_wr)
			case (bus.addr)
			OFS_EXT: ext_q <= bus.wdata[15:0];
			OFS_PC: pc_q <= bus.wdata[15:0];
			OFS_CFG: cfg_q <= bus.wdata;
			default: ext_q <= ext_q;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			total_q <= 8'h00;
			cnt_q <= 8'h00;
			register_access_count <= 4'h0;
			len_q <= 4'h0;
			err_q <= 1'b0;
			run_len <= 8'h00;
		end
		else if (state == ST_DEC)
		begin
			total_q <= next_total;
			cnt_q <= next_total;
			register_access_count <= next_rac;
			len_q <= next_len;
			err_q <= next_err;
			run_len <= 8'h00;
		end
		else if (state == ST_RUN)
		begin
			cnt_q <= cnt_q - 8'h01;
			run_len <= run_len + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			acc_low_half <= WORD_RST;
			acc_high_half <= WORD_RST;
		end
		else if (sw_wr && bus.addr == OFS_ACC)
		begin
			acc_low_half <= bus.wdata[15:0];
			acc_high_half <= bus.wdata[31:16];
		end
		else if (commit)
		begin
			acc_low_half <= next_lo;
			acc_high_half <= next_hi;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			word_general_reg <= '0;
		else if (sw_wr && bus.addr[7:5] == OFS_WREG_HI)
			word_general_reg[bus.addr[4:2]] <= bus.wdata[15:0];
		else if (commit)
			word_general_reg <= next_wreg;
	end

	genvar g;
	generate
		for (g = 0; g < FLAG_BITS; g++)
		begin : g_flag
			always_ff @(posedge clk)
			begin
				if (!rst_b)
					flags[g] <= 1'b0;
				else if (sw_wr && bus.addr == OFS_FLAG)
					flags[g] <= bus.wdata[g];
				else if (commit)
					case (flag_act(nz_op, g))
					FA_CHG: flags[g] <= flag_val[g];
					FA_SET: flags[g] <= 1'b1;
					FA_CLR: flags[g] <= 1'b0;
					default: flags[g] <= flags[g];
					endcase
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			done <= 1'b0;
			mem <= '0;
		end
		else
		begin
			done <= commit || (state == ST_DEC && next_err);
			if (commit)
				mem <= next_mem;
			else
				mem.we <= 1'b0;
		end
	end

	always_comb
	begin
		rmux = 32'h0000_0000;
		if (bus.addr[7:5] == OFS_WREG_HI)
			rmux = {16'h0000, word_general_reg[bus.addr[4:2]]};
		else
			case (bus.addr)
			OFS_CMD: rmux = {18'h00000, sz_q, bsel_q, ea_q, op_q};
			OFS_EXT: rmux = {16'h0000, ext_q};
			OFS_CFG: rmux = cfg_q;
			OFS_ACC: rmux = {acc_high_half, acc_low_half};
			OFS_FLAG: rmux = {25'h0000000, flags};
			OFS_STAT: rmux = {14'h0000, err_q, busy, len_q,
				register_access_count, total_q};
			OFS_RES: rmux = {7'h00, mem.we, mem.data, mem.addr};
			OFS_PC: rmux = {16'h0000, pc_q};
			default: rmux = 32'h0000_0000;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rdata <= 32'h0000_0000;
		else
			rdata <= bus.rd ? rmux : 32'h0000_0000;
	end

	chk_abs_load_ext: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q && op_q == OP_LD_ABS |->
		acc_low_half[15:8] == 8'h00 && acc_high_half == $past(acc_low_half))
		else $error("absolute load did not zero-extend or copy low half");
	chk_sext_fill: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q && (op_q == OP_LDX_ABS || op_q == OP_LDX_EAM) |->
		acc_low_half[15:8] == {8{acc_low_half[7]}})
		else $error("sign-extending load left upper byte wrong");
	chk_swap_clear: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q && (op_q == OP_SWP_A_EAR || op_q == OP_SWP_A_EAM) |->
		acc_low_half[15:8] == 8'h00 && flags == $past(flags))
		else $error("accumulator exchange touched flags or upper byte");
	chk_imm_store: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q && (op_q == OP_ST_IO_IMM || op_q == OP_ST_DIR_IMM)
		|-> mem.we && mem.data == ext_q[15:8] && flags == $past(flags))
		else $error("immediate store wrong data or flags changed");
	chk_ind_store: assert property (@(posedge clk) disable iff (!rst_b)
		commit && op_q == OP_ST_IND |=> mem.we &&
		mem.addr == $past(acc_low_half) && mem.data == $past(acc_high_half[7:0]))
		else $error("indirect store address or data wrong");
	chk_cycle_count: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q |-> run_len == total_q)
		else $error("run length differs from computed cycle total");
	chk_abs_base: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && $past(state) == ST_DEC && op_q == OP_LD_ABS &&
		loc == LOC_INT && fetch == FET_NONE && !cfg_q[CFG_INTM] |->
		total_q == 8'h04 && len_q == 4'h3)
		else $error("absolute load base cost wrong");
	chk_ext_bytes: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_DEC |-> ea.ext_cnt == ((ea_q >= EA_D8_LO &&
		ea_q < EA_D16_LO) ? 2'h1 : (ea_q >= EA_D16_LO && ea_q < 5'h1C) ||
		ea_q >= EA_PCREL ? 2'h2 : 2'h0))
		else $error("extension byte count does not match address code");
	chk_busy_ignore: assert property (@(posedge clk) disable iff (!rst_b)
		busy && bus.wr && bus.addr == OFS_CMD |=> op_q == $past(op_q))
		else $error("command accepted while busy");
	chk_nz_update: assert property (@(posedge clk) disable iff (!rst_b)
		done && !err_q && op_q == OP_LD_ABS |->
		flags[FLG_Z] == (acc_low_half[7:0] == 8'h00) &&
		flags[FLG_N] == acc_low_half[7])
		else $error("negative or zero flag not updated from loaded byte");
endmodule

// *** logic/bme_ea_dec.sv ***
// Effective address field decoder
`timescale 1ns/1ps
module bme_ea_dec
(
	input wire logic [4:0] ea_code,
	input wire bme_pkg::bme_size_t size,
	input wire logic [7:0][15:0] word_general_reg,
	input wire logic [15:0] ext,
	input wire logic [15:0] pc,
	output bme_pkg::bme_ea_t ea
);
	import bme_pkg::*;

	always_comb
	begin
		ea = '0;
		ea.ptr_idx = {1'b0, ea_code[1:0]};
		if (ea_code < EA_MEM_LO)
		begin
			ea.is_reg = 1'b1;
			ea.reg_idx = (size == SZ_LONG) ? {ea_code[2:1], 1'b0} :
				ea_code[2:0];
		end
		else if (ea_code < EA_PINC_LO)
		begin
			ea.addr = word_general_reg[ea_code[1:0]];
			ea.a_cyc = AC_IND;
			ea.a_rac = AR_IND;
		end
		else if (ea_code < EA_D8_LO)
		begin
			ea.addr = word_general_reg[ea_code[1:0]];
			ea.post_inc = 1'b1;
			ea.a_cyc = AC_PINC;
			ea.a_rac = AR_PINC;
		end
		else if (ea_code < EA_D16_LO)
		begin
			ea.addr = word_general_reg[ea_code[2:0]] +
				{{8{ext[7]}}, ext[7:0]};
			ea.ext_cnt = EXT_ONE;
			ea.a_cyc = AC_DISP;
			ea.a_rac = AR_DISP;
		end
		else if (ea_code < 5'h1C)
		begin
			ea.addr = word_general_reg[ea_code[1:0]] + ext;
			ea.ext_cnt = EXT_TWO;
			ea.a_cyc = AC_DISP;
			ea.a_rac = AR_DISP;
		end
		else if (ea_code <= EA_IDX1)
		begin
			ea.addr = word_general_reg[{2'h0, ea_code[0]}] +
				word_general_reg[7];
			ea.a_cyc = AC_IDX;
			ea.a_rac = AR_IDX;
		end
		else if (ea_code == EA_PCREL)
		begin
			ea.addr = pc + ext;
			ea.ext_cnt = EXT_TWO;
			ea.a_cyc = AC_PC;
			ea.a_rac = AR_NONE;
		end
		else
		begin
			ea.addr = ext;
			ea.ext_cnt = EXT_TWO;
			ea.a_cyc = AC_ABS;
			ea.a_rac = AR_NONE;
		end
	end
endmodule

// *** logic/bme_pkg.sv ***
// Constants, types and tables for the byte move and address decoder
package bme_pkg;
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_EXT = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_ACC = 8'h0C;
	localparam logic [7:0] OFS_FLAG = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_RES = 8'h18;
	localparam logic [7:0] OFS_PC = 8'h1C;
	localparam logic [2:0] OFS_WREG_HI = 3'h1;
	localparam int CMD_OP = 0;
	localparam int CMD_EA = 4;
	localparam int CMD_BSEL = 9;
	localparam int CMD_SZ = 12;
	localparam int CFG_LOC = 0;
	localparam int CFG_FETCH = 2;
	localparam int CFG_INTM = 4;
	localparam int CFG_WAIT = 8;
	localparam int CFG_MEM = 16;
	localparam int CFG_DPR = 24;
	localparam int FLAG_BITS = 7;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [4:0] EA_MEM_LO = 5'h08;
	localparam logic [4:0] EA_PINC_LO = 5'h0C;
	localparam logic [4:0] EA_D8_LO = 5'h10;
	localparam logic [4:0] EA_D16_LO = 5'h18;
	localparam logic [4:0] EA_IDX1 = 5'h1D;
	localparam logic [4:0] EA_PCREL = 5'h1E;
	localparam logic [4:0] EA_ABS = 5'h1F;
	localparam logic [2:0] AC_IND = 3'h2;
	localparam logic [1:0] AR_IND = 2'h1;
	localparam logic [2:0] AC_PINC = 3'h4;
	localparam logic [1:0] AR_PINC = 2'h2;
	localparam logic [2:0] AC_DISP = 3'h2;
	localparam logic [1:0] AR_DISP = 2'h1;
	localparam logic [2:0] AC_IDX = 3'h4;
	localparam logic [1:0] AR_IDX = 2'h2;
	localparam logic [2:0] AC_PC = 3'h2;
	localparam logic [2:0] AC_ABS = 3'h1;
	localparam logic [1:0] AR_NONE = 2'h0;
	localparam logic [1:0] EXT_ONE = 2'h1;
	localparam logic [1:0] EXT_TWO = 2'h2;
	localparam logic [3:0] COR_W_ODD_INT = 4'h2;
	localparam logic [3:0] COR_L_ODD_INT = 4'h4;
	localparam logic [3:0] COR_E16_EVEN = 4'h1;
	localparam logic [3:0] COR_L_E16_EVEN = 4'h2;
	localparam logic [3:0] COR_B_EXT = 4'h1;
	localparam logic [3:0] COR_W_EXT = 4'h4;
	localparam logic [3:0] COR_L_EXT = 4'h8;
	localparam logic [2:0] ACC_ONE = 3'h1;
	localparam logic [2:0] ACC_TWO = 3'h2;
	localparam logic [2:0] ACC_FOUR = 3'h4;
	localparam logic [7:0] FET_INT_CYC = 8'h02;
	localparam logic [7:0] FET_EXT_CYC = 8'h03;
	localparam logic [15:0] STEP_B = 16'h0001;
	localparam logic [15:0] STEP_W = 16'h0002;
	localparam logic [15:0] STEP_L = 16'h0004;
	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1,
		SZ_LONG = 2'h2} bme_size_t;
	typedef enum logic [1:0] {LOC_INT = 2'h0, LOC_EXT16 = 2'h1,
		LOC_EXT8 = 2'h2} bme_loc_t;
	typedef enum logic [1:0] {FET_NONE = 2'h0, FET_INT_WORD = 2'h1,
		FET_E16_WORD = 2'h2, FET_E8_BYTE = 2'h3} bme_fetch_t;
	typedef enum logic [1:0] {FA_KEEP = 2'h0, FA_CHG = 2'h1, FA_SET = 2'h2,
		FA_CLR = 2'h3} bme_fact_t;
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_DEC = 3'b010,
		ST_RUN = 3'b100} bme_state_t;
	typedef enum logic [3:0] {OP_LD_ABS = 4'h0, OP_LDX_ABS = 4'h1,
		OP_LD_EAM = 4'h2, OP_LDX_EAM = 4'h3, OP_LD_EAR = 4'h4,
		OP_ST_IND = 4'h5, OP_ST_IO_IMM = 4'h6, OP_ST_DIR_IMM = 4'h7,
		OP_SWP_A_EAR = 4'h8, OP_SWP_A_EAM = 4'h9, OP_SWP_R_EAR = 4'hA,
		OP_SWP_R_EAM = 4'hB} bme_op_t;
	localparam logic [7:0] BASE_CYC [0:11] = '{8'h04, 8'h04, 8'h03, 8'h02,
		8'h02, 8'h03, 8'h05, 8'h05, 8'h04, 8'h05, 8'h07, 8'h09};
	localparam logic [3:0] BASE_LEN [0:11] = '{4'h3, 4'h3, 4'h2, 4'h2,
		4'h2, 4'h2, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2};
	localparam logic [3:0] BASE_RAC [0:11] = '{4'h0, 4'h0, 4'h0, 4'h0,
		4'h1, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h4, 4'h2};
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bme_bus_t;
	typedef struct packed {
		logic is_reg;
		logic [2:0] reg_idx;
		logic [2:0] ptr_idx;
		logic post_inc;
		logic [1:0] ext_cnt;
		logic [2:0] a_cyc;
		logic [1:0] a_rac;
		logic [15:0] addr;
	} bme_ea_t;
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} bme_mem_t;
endpackage

// *** tb/bme_mem_model.sv ***
// Memory side model that records byte writes from the executor
`timescale 1ns/1ps
module bme_mem_model
(
	input wire logic clk,
	input wire bme_pkg::bme_mem_t mem,
	output logic [31:0] last_wr,
	output int n_wr
);
	import bme_pkg::*;
	logic [23:0] wr_q [$];
	// Plain byte writes only, nothing is read back and rewritten
	always @(posedge clk)
	begin
		if (mem.we === 1'b1)
		begin
			wr_q.push_back({mem.addr, mem.data});
			last_wr <= {8'h00, wr_q[$]};
			n_wr <= n_wr + 1;
		end
	end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the byte move executor
`timescale 1ns/1ps
module testbench;
	import bme_pkg::*;
	localparam int am [24] = '{210, 210, 210, 210, 420, 420, 420, 420,
		211, 211, 211, 211, 211, 211, 211, 211, 212, 212, 212, 212,
		420, 420, 202, 102};
	logic clk, rst_b, busy, done;
	bme_bus_t bus;
	bme_mem_t mem;
	logic [31:0] rdata, last_wr, acc, c, d, e, xw;
	logic [7:0] mb, dpr, b;
	logic [6:0] fl;
	logic [15:0] w [8];
	logic [15:0] pc, xa, pw;
	int n_wr, errors, n_compared, loc, fet, intm, wt;
	int op, ea, sz, r, rs, t, len, rac, ac, nw, m;
	bme_byte_move uut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.busy(busy), .done(done), .mem(mem));
	bme_mem_model mm (.clk(clk), .mem(mem), .last_wr(last_wr), .n_wr(n_wr));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task stop_test;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	// Command, then an accumulator or command write ignored while busy
	task run(input logic [31:0] cmd, input int n);
		int k;
		bus <= '{OFS_CMD, cmd, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '{($urandom % 2) ? OFS_ACC : OFS_CMD, 32'hDEAD_BEEF,
			1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		#1 cmp(busy, n != 0);
		k = 1;
		while (done !== 1'b1 && k < 400)
		begin
			@(posedge clk);
			#1 k++;
		end
		cmp(k, n + 1);
		@(posedge clk);
	endtask
	task chk(input logic [31:0] s);
		rd(OFS_STAT, d);
		cmp(d, s);
		rd(OFS_ACC, d);
		cmp(d, acc);
		rd(OFS_FLAG, d);
		cmp(d, {25'h0, fl});
	endtask
	task prep;
		loc = $urandom % 3;
		fet = $urandom % 4;
		intm = $urandom % 2;
		wt = $urandom % 4;
		mb = 8'($urandom);
		dpr = 8'($urandom);
		acc = $urandom;
		fl = 7'($urandom);
		pc = 16'($urandom);
		wr(OFS_CFG, {dpr, mb, 4'h0, wt[3:0], 3'h0, intm[0], fet[1:0],
			loc[1:0]});
		wr(OFS_ACC, acc);
		wr(OFS_FLAG, {25'h0, fl});
		wr(OFS_PC, {16'h0, pc});
	endtask
	task nz(input logic [7:0] v);
		fl[FLG_N] = v[7];
		fl[FLG_Z] = (v == 8'h00);
	endtask
	task ld(input logic s, input logic [7:0] v);
		acc = {acc[15:0], s ? {8{v[7]}} : 8'h00, v};
		nz(v);
	endtask
	// Operand correction plus external waits for one operand
	function int xc(int s, int odd);
		int sl;
		sl = (loc == 2) || odd;
		if (loc == 0)
			return odd ? 2 * s : 0;
		return (sl ? (s ? 4 * s : 1) : (s == 2 ? 2 : 1))
			+ wt * (sl ? 1 << s : (s == 2 ? 2 : 1));
	endfunction
	// Operand address for a memory address code
	function logic [15:0] ad(int c);
		if (c < 16)
			return w[c % 4];
		if (c < 24)
			return w[c % 8] + {{8{e[7]}}, e[7:0]};
		if (c < 28)
			return w[c % 4] + e[15:0];
		if (c < 30)
			return w[c % 2] + w[7];
		return (c == 30) ? pc + e[15:0] : e[15:0];
	endfunction
	initial
	begin
		#(40 * 80000);
		errors++;
		stop_test;
	end
	initial
	begin
		bus = '0;
		rst_b = 1'b0;
		errors = 0;
		n_compared = 0;
		void'($urandom(32'hFF585FFA));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Reset values and an unmapped read
		for (int a = 4; a < 68; a += 4)
		begin
			rd(a == 64 ? 8'hFC : 8'(a), d);
			cmp(d, 32'h0);
		end
		for (int i = 0; i < 8; i++)
		begin
			w[i] = 16'($urandom);
			wr(8'h20 + 8'(4 * i), {16'h0, w[i]});
		end
		for (int n = 0; n < 240; n++)
		begin
			op = n % 12;
			prep;
			e = $urandom;
			wr(OFS_EXT, e);
			r = $urandom % 8;
			rs = $urandom % 8;
			ea = (op == 4 || op == 8 || op == 10) ? r :
				(op inside {2, 3, 9, 11}) ? 8 + (5 * (n / 12) + op) % 24 : 0;
			sz = (ea == 31) ? $urandom % 3 : 0;
			if (ea >= 8)
				r = ea % 4;
			xa = ad(ea);
			pw = w[ea % 4];
			nw = n_wr;
			rac = 0;
			len = 2;
			case (op)
				0, 1:
				begin
					len = 3;
					t = 4 + xc(0, e[0]);
					ld(op == 1, mb);
				end
				2, 3, 9, 11:
				begin
					ac = am[ea - 8];
					m = (op > 3) ? 2 : 1;
					rac = ac / 10 % 10 + ((op == 11) ? 2 : 0);
					len = 2 + ac % 10;
					t = ((op == 2) ? 3 : (op == 3) ? 2 : (op == 9) ? 5 : 9)
						+ ac / 100 + m * xc(sz, xa[0]);
					if (op < 4)
						ld(op == 3, mb);
					else if (op == 9)
					begin
						xw = {8'h00, xa, acc[7:0]};
						acc[15:0] = {8'h00, mb};
					end
					else
					begin
						xw = {8'h00, xa, w[rs][7:0]};
						w[rs][7:0] = mb;
					end
				end
				4:
				begin
					rac = 1;
					t = 2;
					ld(1'b0, w[r][7:0]);
				end
				5:
				begin
					t = 3 + xc(0, acc[0]);
					xw = {8'h00, acc[15:0], acc[23:16]};
					nz(acc[23:16]);
				end
				6, 7:
				begin
					len = 3;
					t = 5 + xc(0, e[0]);
					xw = {8'h00, op == 7 ? dpr : 8'h00, e[7:0], e[15:8]};
				end
				8:
				begin
					rac = 2;
					t = 4;
					b = acc[7:0];
					acc[15:0] = {8'h00, w[r][7:0]};
					w[r][7:0] = b;
				end
				default:
				begin
					rac = 4;
					t = 7;
					b = w[r][7:0];
					w[r][7:0] = w[rs][7:0];
					w[rs][7:0] = b;
				end
			endcase
			if (ea >= 12 && ea < 16)
				w[ea - 12] = pw + STEP_B;
			t = t + ((fet == 0) ? 0 : (fet == 1) ? 2 : 3) + intm * rac;
			c = {18'h0, sz[1:0], rs[2:0], ea[4:0], op[3:0]};
			run(c, t);
			chk({16'h0, len[3:0], rac[3:0], t[7:0]});
			if (op inside {5, 6, 7, 9, 11})
			begin
				cmp(n_wr, nw + 1);
				cmp(last_wr, xw);
			end
			if (op inside {2, 3, 4, 8, 9, 10, 11})
			begin
				rd(8'h20 + 8'(4 * r), d);
				cmp(d, {16'h0, w[r]});
				rd(8'h20 + 8'(4 * rs), d);
				cmp(d, {16'h0, w[rs]});
			end
		end
		// Wrong operand class and an unknown operation are refused
		for (int j = 0; j < 2; j++)
		begin
			run(j ? 32'h0000_000F : 32'h0000_0104, 0);
			rd(OFS_STAT, d);
			cmp(d & 32'h0002_00FF, 32'h0002_0001);
			rd(OFS_ACC, d);
			cmp(d, acc);
		end
		stop_test;
	end
endmodule
